// *** bench/far_end_model.sv ***
// Far-end transmitter model: sends one word on the receive pairs per request.
// Assumes the bench holds word steady and drops send once busy is seen.
`timescale 1ns/10ps
module far_end_model
   import lvds_link_pkg::*;
(
   // Link clock and request
   input wire logic link_clk,
   input wire logic [lvds_link_pkg::WORD_W-1:0] word,
   input wire logic send,
   // Serial side
   output logic [lvds_link_pkg::LANES-1:0] pair,
   output logic fwd,
   output logic busy
);
   int slot = 7; // Seven means idle
   int s; // Slot being sent
   initial begin
      pair = 3'h0;
      fwd = 1'b0;
   end
   assign busy = (slot < 7);
   // One slot per link clock; idle lines flip so stale bits never pass as data
   always @(posedge link_clk) begin
      s = (slot < 7) ? slot : 0;
      if (slot < 7 || send) begin
         for (int l = 0; l < LANES; l++) pair[l] <= word[SLOTS * l + s];
         fwd <= (s < 4);
         slot <= s + 1;
      end else begin
         pair <= ~pair;
         fwd <= 1'b0; // Clock stands still between words
      end
   end
endmodule : far_end_model

// *** bench/link_checker_asserts.sv ***
// Concurrent checks on the pins of the pixel link top level.
// Assumes it is bound to lvds_pixel_serdes_link; every check runs on clk.
`timescale 1ns/10ps
module link_checker
   import lvds_link_pkg::*;
#(parameter int LOCK_CYCLES = 20) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Transmit pins
   input wire logic tx_power_down_n,
   input wire logic tx_serial_oe,
   input wire logic tx_forwarded_clock,
   // Receive pins
   input wire logic rx_power_down_n,
   input wire logic [lvds_link_pkg::WORD_W-1:0] rx_parallel_out,
   input wire logic shift_clock_out,
   input wire logic rx_locked
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [15:0] run_ff; // Cycles since reset or receive power-down, saturating
   // Run counter; a lock earlier than this count is premature
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) run_ff <= 16'h0;
      else if (!rx_power_down_n) run_ff <= 16'h0;
      else if (run_ff != 16'hffff) run_ff <= run_ff + 16'h1;
   end
   // Four slots high, then three low
   sequence fwd_word_s;
      tx_forwarded_clock [*4] ##1 !tx_forwarded_clock [*3];
   endsequence
   AST_TX_OE_OFF: assert property (!tx_power_down_n |-> !tx_serial_oe)
      else $error("serial drivers on during power-down");
   AST_TX_OE_ON: assert property ($rose(tx_serial_oe) |-> tx_power_down_n && $past(tx_power_down_n, 2))
      else $error("serial drivers on too early");
   AST_TX_FWD: assert property (disable iff (!arst_n || !tx_power_down_n) $rose(tx_forwarded_clock) |-> fwd_word_s)
      else $error("forwarded clock shape wrong");
   AST_RX_PULSE: assert property ($fell(shift_clock_out) |=> $rose(shift_clock_out))
      else $error("shift clock low not one cycle");
   AST_RX_SETTLED: assert property (!shift_clock_out |-> $stable(rx_parallel_out))
      else $error("data moved while shift clock low");
   AST_RX_HOLD: assert property (!rx_power_down_n [*5] |-> $stable(rx_parallel_out) && shift_clock_out)
      else $error("outputs moved in power-down");
   AST_RX_PD_TIME: assert property ($fell(rx_power_down_n) |-> ##[1:10] !rx_locked)
      else $error("receiver not down in time");
   AST_RX_LOCK: assert property ($rose(rx_locked) |-> run_ff >= LOCK_CYCLES)
      else $error("lock came too early");
endmodule : link_checker
bind lvds_pixel_serdes_link link_checker #(.LOCK_CYCLES(LOCK_CYCLES)) link_checker_i (.clk, .arst_n,
   .tx_power_down_n, .tx_serial_oe, .tx_forwarded_clock, .rx_power_down_n, .rx_parallel_out,
   .shift_clock_out, .rx_locked);

// *** bench/tb_top.sv ***
// Self-checking bench for the pixel link: transmit words, power-down, receive path.
// Assumes the far-end model on the receive pairs and a 160 ns link clock.
`timescale 1ns/10ps
module tb_top;
   import lvds_link_pkg::*;
   localparam int LOCK = 20; // Short lock wait for simulation
   logic clk = 0, link_clk = 0, arst_n = 0, ce = 1, sci = 1, tx_pd_n = 1, rx_pd_n = 1, send = 0;
   logic [WORD_W-1:0] tx_word = '0, rx_word = '0, rx_out;
   logic [LANES-1:0] tx_pair, rx_pair;
   logic fwd_out, oe, fwd_in, sco, locked, busy;
   int n_errors = 0, num_checks = 0, cycles = 0;
   logic [WORD_W-1:0] words [3] = '{21'h1fffff, 21'h155555, 21'h0a0f3c}; // Word patterns
   initial forever #50 clk = ~clk;
   initial begin
      #37;
      forever #80 link_clk = ~link_clk;
   end
   lvds_pixel_serdes_link #(.LOCK_CYCLES(LOCK)) lvds_pixel_serdes_link_i (.clk, .arst_n, .ce,
      .link_clk, .shift_clock_in(sci), .tx_parallel_in(tx_word), .tx_power_down_n(tx_pd_n),
      .tx_serial_pair(tx_pair), .tx_forwarded_clock(fwd_out), .tx_serial_oe(oe),
      .rx_serial_pair(rx_pair), .rx_forwarded_clock(fwd_in), .rx_power_down_n(rx_pd_n),
      .rx_parallel_out(rx_out), .shift_clock_out(sco), .rx_locked(locked));
   far_end_model far_end_model_i (.link_clk, .word(rx_word), .send, .pair(rx_pair),
      .fwd(fwd_in), .busy);
   task end_of_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t bit mismatch", $time);
      end
   endtask : chk_bit
   task chk_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t word mismatch", $time);
      end
   endtask : chk_word
   // Pin fall, capture three edges later, then seven slots; 14-cycle spacing
   task t_tx_word(input logic [WORD_W-1:0] w);
      tx_word <= w;
      sci <= 1'b0;
      repeat (3) @(posedge clk);
      for (int s = 0; s < SLOTS; s++) begin
         @(negedge clk);
         for (int l = 0; l < LANES; l++) chk_bit(tx_pair[l], w[SLOTS * l + s]);
         chk_bit(fwd_out, s < 4);
      end
      @(posedge clk) sci <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : t_tx_word
   task t_tx_pd;
      tx_pd_n <= 1'b0;
      @(negedge clk) chk_bit(oe, 1'b0);
      @(posedge clk) tx_pd_n <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk) chk_bit(oe, 1'b1);
      @(posedge clk);
   endtask : t_tx_pd
   task rx_send(input logic [WORD_W-1:0] w);
      int i;
      rx_word <= w;
      send <= 1'b1;
      for (i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk);
      send <= 1'b0;
      for (i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk);
   endtask : rx_send
   task t_rx_word(input logic [WORD_W-1:0] w);
      rx_send(w);
      for (int i = 0; i < 40 && sco !== 1'b0; i++) @(negedge clk);
      chk_bit(sco, 1'b0);
      chk_word(rx_out, w);
      @(posedge clk);
   endtask : t_rx_word
   // New word sent while down must not reach the outputs
   task t_rx_pd(input logic [WORD_W-1:0] held);
      rx_pd_n <= 1'b0;
      repeat (10) @(posedge clk);
      @(negedge clk) chk_bit(locked, 1'b0);
      @(posedge clk) rx_send(~held);
      repeat (10) @(posedge clk);
      @(negedge clk) chk_word(rx_out, held);
      @(posedge clk) rx_pd_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : t_rx_pd
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         end_of_test();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      // First capture then lands on the free-running slot zero, so no word is cut short
      repeat (7) @(posedge clk);
      for (int k = 0; k < 3; k++) t_tx_word(words[k]);
      t_tx_pd();
      t_rx_word(words[0]);
      chk_bit(locked, 1'b0);
      repeat (LOCK + 5) @(posedge clk);
      @(negedge clk) chk_bit(locked, 1'b1);
      @(posedge clk) t_rx_word(words[1]);
      t_rx_pd(words[1]);
      t_rx_word(words[2]);
      end_of_test();
   end
endmodule : tb_top

// *** src/lvds_link_pkg.sv ***
// Shared constants for the serial pixel link: word layout, slot counts, timing.
// Assumes a 10 MHz system clock; every number the link logic needs lives here.
package lvds_link_pkg;
   // Parallel word layout
   localparam int WORD_W = 21;         // Colour plus control bits
   localparam int COLOR_W = 6;         // Bits per colour
   localparam int RED_LSB = 0;         // Red field low bit
   localparam int GREEN_LSB = 6;       // Green field low bit
   localparam int BLUE_LSB = 12;       // Blue field low bit
   localparam int LINE_BIT = 18;       // Line pulse position
   localparam int FRAME_BIT = 19;      // Frame pulse position
   localparam int VALID_BIT = 20;      // Data valid strobe position
   // Serial layout
   localparam int LANES = 3;           // Data pairs
   localparam int SLOTS = 7;           // Bits per pair per clock
   localparam logic [2:0] SLOT_FIRST = 3'h0;     // Position zero
   localparam logic [2:0] SLOT_LAST = 3'h6;      // Final position
   localparam logic [2:0] FWD_HIGH_LAST = 3'h3;  // Forwarded clock high in slots 0..3
   // Timing
   localparam int CLK_PERIOD_NS = 100;           // System clock period
   localparam int TX_PD_NS = 100;                // Transmit power-down limit
   localparam int TX_PD_CYCLES = (TX_PD_NS / CLK_PERIOD_NS < 1) ? 1 : TX_PD_NS / CLK_PERIOD_NS;
   localparam int RX_PD_US = 1;                  // Receive power-down limit
   localparam int RX_PD_CYCLES = (RX_PD_US * 1000) / CLK_PERIOD_NS;
   localparam int LOCK_MS = 10;                  // Receive lock time
   localparam int LOCK_CYCLES_DEF = (LOCK_MS * 1000000) / CLK_PERIOD_NS;

   // Bit index of a lane/slot pair inside the parallel word
   function automatic int map_idx(input int lane, input logic [2:0] slot);
      map_idx = lane * SLOTS + int'(slot);
   endfunction : map_idx

   // Slot counter advance with wrap after the last position
   function automatic logic [2:0] next_slot(input logic [2:0] slot);
      next_slot = (slot == SLOT_LAST) ? SLOT_FIRST : slot + 3'h1;
   endfunction : next_slot
endpackage : lvds_link_pkg

// *** src/lvds_pixel_serdes_link.sv ***
// Transmit serializer and receive deserializer of a three-pair pixel link.
// Assumes clk is the serial bit clock on the transmit side (pixel clock at most clk/7)
// and link_clk is the receive bit clock, in step with the incoming pairs.
`timescale 1ns/10ps
module lvds_pixel_serdes_link #(
   parameter int LOCK_CYCLES = lvds_link_pkg::LOCK_CYCLES_DEF   // Lock wait in clk cycles
) (
   // System clock, reset, enable
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   // Receive bit clock
   input wire logic link_clk,
   // Transmit parallel side
   input wire logic shift_clock_in,
   input wire logic [lvds_link_pkg::WORD_W-1:0] tx_parallel_in,
   input wire logic tx_power_down_n,
   // Transmit serial side
   output logic [lvds_link_pkg::LANES-1:0] tx_serial_pair,
   output logic tx_forwarded_clock,
   output logic tx_serial_oe,
   // Receive serial side
   input wire logic [lvds_link_pkg::LANES-1:0] rx_serial_pair,
   input wire logic rx_forwarded_clock,
   input wire logic rx_power_down_n,
   // Receive parallel side
   output logic [lvds_link_pkg::WORD_W-1:0] rx_parallel_out,
   output logic shift_clock_out,
   output logic rx_locked
);
   import lvds_link_pkg::*;

   localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);   // Lock counter width

   // Reset synchronisers, one per domain
   logic [1:0] rst_sync_ff;       // System domain release
   logic [1:0] link_rst_ff;       // Link domain release
   logic rst_n;
   logic link_rst_n;
   logic tx_pd_clr_n;             // Immediate clear for transmit drivers

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         link_rst_ff <= 2'h0;
      end else begin
         link_rst_ff <= {link_rst_ff[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_ff[1];
   assign link_rst_n = link_rst_ff[1];
   // A synchronised path would take two cycles, longer than the allowed delay
   assign tx_pd_clr_n = rst_n & tx_power_down_n;

   // Pin synchronisers in the system domain
   logic [WORD_W-1:0] txd_s1_ff, txd_s2_ff;       // Parallel data stages
   logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;      // Shift clock stages, third for edge
   logic txpd_s1_ff, txpd_s2_ff;                  // Transmit power-down level
   logic rxpd_s1_ff, rxpd_s2_ff;                  // Receive power-down level
   logic tgl_s1_ff, tgl_s2_ff, tgl_s3_ff;         // Word-ready toggle from link side
   logic tgl_link_ff, nxt_tgl_link;               // Flips once per completed word, link side

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txd_s1_ff <= '0;
         txd_s2_ff <= '0;
         {sclk_s1_ff, sclk_s2_ff, sclk_s3_ff} <= 3'h0;
         {rxpd_s1_ff, rxpd_s2_ff} <= 2'h0;
         {tgl_s1_ff, tgl_s2_ff, tgl_s3_ff} <= 3'h0;
      end else if (ce) begin
         txd_s1_ff <= tx_parallel_in;
         txd_s2_ff <= txd_s1_ff;
         {sclk_s1_ff, sclk_s2_ff, sclk_s3_ff} <= {shift_clock_in, sclk_s1_ff, sclk_s2_ff};
         {rxpd_s1_ff, rxpd_s2_ff} <= {rx_power_down_n, rxpd_s1_ff};
         {tgl_s1_ff, tgl_s2_ff, tgl_s3_ff} <= {tgl_link_ff, tgl_s1_ff, tgl_s2_ff};
      end
   end

   // Power-down level sync, emptied by the same clear as the drivers
   // Stale high stages would switch the drivers on, off, on after a short pulse
   always_ff @(posedge clk or negedge tx_pd_clr_n) begin
      if (!tx_pd_clr_n) begin
         {txpd_s1_ff, txpd_s2_ff} <= 2'h0;
      end else if (ce) begin
         {txpd_s1_ff, txpd_s2_ff} <= {tx_power_down_n, txpd_s1_ff};
      end
   end

   // Transmit serializer state
   logic [WORD_W-1:0] tx_word_ff, nxt_tx_word;    // Word being sent
   logic [2:0] tx_slot_ff, nxt_tx_slot;           // Position within the clock
   logic [LANES-1:0] tx_ser_ff, nxt_tx_ser;       // Serial bit per pair
   logic tx_fwd_ff, nxt_tx_fwd;                   // Forwarded clock level
   logic tx_capture;                              // Falling edge seen

   // Next transmit values; the word repeats until a new edge arrives
   always_comb begin
      tx_capture = ~sclk_s2_ff & sclk_s3_ff;
      nxt_tx_word = tx_word_ff;
      nxt_tx_slot = next_slot(tx_slot_ff);
      if (tx_capture) begin
         nxt_tx_word = txd_s2_ff;
         nxt_tx_slot = SLOT_FIRST;
      end
      for (int l = 0; l < LANES; l++) begin
         nxt_tx_ser[l] = nxt_tx_word[map_idx(l, nxt_tx_slot)];
      end
      nxt_tx_fwd = (nxt_tx_slot <= FWD_HIGH_LAST);
   end

   // Serializer registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_word_ff <= '0;
         tx_slot_ff <= SLOT_LAST;                 // First slot after release is zero
         tx_ser_ff <= '0;
         tx_fwd_ff <= 1'b0;
      end else if (ce) begin
         tx_word_ff <= nxt_tx_word;
         tx_slot_ff <= nxt_tx_slot;
         tx_ser_ff <= nxt_tx_ser;
         tx_fwd_ff <= nxt_tx_fwd;
      end
   end

   // Driver enable: cleared at once by power-down, set again after sync
   logic tx_oe_ff, nxt_tx_oe;
   always_comb begin
      nxt_tx_oe = txpd_s2_ff;
   end

   always_ff @(posedge clk or negedge tx_pd_clr_n) begin
      if (!tx_pd_clr_n) begin
         tx_oe_ff <= 1'b0;
      end else if (ce) begin
         tx_oe_ff <= nxt_tx_oe;
      end
   end

   assign tx_serial_pair = tx_ser_ff;
   assign tx_forwarded_clock = tx_fwd_ff;
   assign tx_serial_oe = tx_oe_ff;

   // Link domain: enable crosses as a level
   logic ce_l1_ff, ce_l2_ff;
   // Link domain deserializer state
   logic fwd_prev_ff;                             // Previous forwarded clock sample
   logic [2:0] rx_slot_ff, nxt_rx_slot;           // Position of the next bit
   logic [WORD_W-1:0] asm_ff, nxt_asm;            // Word being assembled
   logic [WORD_W-1:0] hold_ff, nxt_hold;          // Completed word, stable for crossing
   logic rx_run_ff, nxt_rx_run;                   // Inside a word, slots 1..6 still due
   logic rx_rise;                                 // Forwarded clock rose at this sample
   logic rx_active;                               // This sample belongs to a word
   logic [2:0] rx_cur;                            // Slot of the bit now sampled

   // Rising forwarded clock marks position zero
   // Nothing is assembled while the clock stands still, so idle lines never form a word
   always_comb begin
      rx_rise = rx_forwarded_clock & ~fwd_prev_ff;
      rx_active = rx_rise | rx_run_ff;
      rx_cur = rx_rise ? SLOT_FIRST : rx_slot_ff;
      nxt_rx_slot = next_slot(rx_cur);
      nxt_rx_run = rx_active & (rx_cur != SLOT_LAST);
      nxt_asm = asm_ff;
      nxt_hold = hold_ff;
      nxt_tgl_link = tgl_link_ff;
      if (rx_active) begin
         for (int l = 0; l < LANES; l++) begin
            nxt_asm[map_idx(l, rx_cur)] = rx_serial_pair[l];
         end
         if (rx_cur == SLOT_LAST) begin
            nxt_hold = nxt_asm;
            nxt_tgl_link = ~tgl_link_ff;
         end
      end
   end

   // Deserializer registers; hold stays put for many clk cycles between toggles
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         {ce_l1_ff, ce_l2_ff} <= 2'h0;
         fwd_prev_ff <= 1'b0;
         rx_slot_ff <= SLOT_FIRST;
         asm_ff <= '0;
         hold_ff <= '0;
         tgl_link_ff <= 1'b0;
         rx_run_ff <= 1'b0;
      end else begin
         {ce_l1_ff, ce_l2_ff} <= {ce, ce_l1_ff};
         if (ce_l2_ff) begin
            fwd_prev_ff <= rx_forwarded_clock;
            rx_slot_ff <= nxt_rx_slot;
            asm_ff <= nxt_asm;
            hold_ff <= nxt_hold;
            tgl_link_ff <= nxt_tgl_link;
            rx_run_ff <= nxt_rx_run;
         end
      end
   end

   // Receive output side in the system domain
   logic [WORD_W-1:0] rx_out_ff, nxt_rx_out;      // Parallel output word
   logic pend_ff, nxt_pend;                       // Word loaded, clock fall due
   logic sclk_out_ff, nxt_sclk_out;               // Regenerated shift clock
   logic seen_ff, nxt_seen;                       // First received word has been loaded
   logic [LOCK_W-1:0] lock_cnt_ff, nxt_lock_cnt;  // Lock wait counter
   logic locked_ff, nxt_locked;                   // Lock reached
   logic new_word;

   // Load new word with clock high, fall one cycle later
   always_comb begin
      new_word = (tgl_s2_ff ^ tgl_s3_ff) & rxpd_s2_ff;
      nxt_rx_out = new_word ? hold_ff : rx_out_ff;
      nxt_pend = new_word;
      nxt_sclk_out = ~pend_ff;
      nxt_seen = seen_ff;
      nxt_lock_cnt = lock_cnt_ff;
      nxt_locked = locked_ff;
      if (!rxpd_s2_ff) begin
         // Power-down drops lock; data and clock simply stop changing
         nxt_seen = 1'b0;
         nxt_lock_cnt = '0;
         nxt_locked = 1'b0;
         nxt_sclk_out = sclk_out_ff;
      end else if (!seen_ff) begin
         nxt_seen = new_word;
      end else if (lock_cnt_ff == LOCK_W'(LOCK_CYCLES)) begin
         nxt_locked = 1'b1;
      end else begin
         nxt_lock_cnt = lock_cnt_ff + LOCK_W'(1);
      end
   end

   // Receive output registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_out_ff <= '0;
         pend_ff <= 1'b0;
         sclk_out_ff <= 1'b1;
         seen_ff <= 1'b0;
         lock_cnt_ff <= '0;
         locked_ff <= 1'b0;
      end else if (ce) begin
         rx_out_ff <= nxt_rx_out;
         pend_ff <= nxt_pend;
         sclk_out_ff <= nxt_sclk_out;
         seen_ff <= nxt_seen;
         lock_cnt_ff <= nxt_lock_cnt;
         locked_ff <= nxt_locked;
      end
   end

   assign rx_parallel_out = rx_out_ff;
   assign shift_clock_out = sclk_out_ff;
   assign rx_locked = locked_ff;
endmodule : lvds_pixel_serdes_link
